// [hw/rtcac_pkg.sv]
package rtcac_pkg;

  // Clock and timebase
  localparam int CLK_PERIOD_NS   = 10;
  localparam int HALF_SEC_NS     = 500_000_000;
  localparam int HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;

  // Register byte offsets on the peripheral bus
  localparam logic [7:0] OFF_ALCFG   = 8'h00;
  localparam logic [7:0] OFF_ALVAL   = 8'h04;
  localparam logic [7:0] OFF_YEAR    = 8'h08;
  localparam logic [7:0] OFF_CALENDAR_MONTH_DAY_VALUE   = 8'h0c;
  localparam logic [7:0] OFF_CTRL    = 8'h10;
  localparam logic [7:0] OFF_IRQ_STS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h18;
  localparam logic [7:0] OFF_TIME    = 8'h1c;

  // Field positions
  localparam int MASK_LSB      = 10;
  localparam int PTR_LSB       = 8;
  localparam int CTRL_WREN_BIT = 0;
  localparam int CTRL_ALEN_BIT = 1;
  localparam int CTRL_CHIME_BIT = 2;
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_WBLK_BIT  = 1;

  // Implemented bits and values after reset
  localparam logic [15:0] CALENDAR_MONTH_DAY_VALUE_MASK = 16'h1f3f;
  localparam logic [15:0] CALENDAR_MONTH_DAY_VALUE_RST  = 16'h0101;
  localparam logic [7:0]  YEAR_RST   = 8'h00;

  // BCD limits and roll-over points
  localparam logic [3:0] BCD_MAX      = 4'h9;
  localparam logic [2:0] TENS_MAX_MS  = 3'h5;
  localparam logic [1:0] HR_TENS_LAST = 2'h2;
  localparam logic [3:0] HR_ONES_LAST = 4'h3;
  localparam logic [2:0] WDAY_LAST    = 3'h6;

  typedef enum logic [3:0] {
    MASK_HALF_SEC = 4'h0,
    MASK_SEC      = 4'h1,
    MASK_TEN_SEC  = 4'h2,
    MASK_MIN      = 4'h3,
    MASK_TEN_MIN  = 4'h4,
    MASK_HOUR     = 4'h5,
    MASK_DAY      = 4'h6,
    MASK_WEEK     = 4'h7,
    MASK_MONTH    = 4'h8,
    MASK_YEAR     = 4'h9
  } rtcac_mask_t;

  // Word index of the alarm store selected by the window pointer
  typedef enum logic [1:0] {
    PTR_MTH_SEC = 2'h0,
    PTR_WDY_HR  = 2'h1,
    PTR_MIN_DAY = 2'h2,
    PTR_PWC     = 2'h3
  } rtcac_ptr_t;

endpackage

// [hw/rtcac_core_if.sv]
`timescale 1ns/1ps
interface rtcac_core_if;
  // Timebase events and current time
  logic             half;
  logic             sec;
  logic             ten_sec;
  logic             minute;
  logic             ten_min;
  logic             hour;
  logic             day;
  logic [7:0]       sec_bcd;
  logic [7:0]       min_bcd;
  logic [7:0]       hr_bcd;
  logic [2:0]       wday;
  // Alarm value store
  logic             wr_en;
  logic [1:0]       idx;
  logic [15:0]      wr_data;
  logic [15:0]      rd_data;
  logic [3:0][15:0] words;

  modport timebase (output half, sec, ten_sec, minute, ten_min, hour, day,
                    output sec_bcd, min_bcd, hr_bcd, wday);
  modport store    (input wr_en, idx, wr_data, output rd_data, words);
  modport core     (input half, sec, ten_sec, minute, ten_min, hour, day,
                    input sec_bcd, min_bcd, hr_bcd, wday, rd_data, words,
                    output wr_en, idx, wr_data);
endinterface

// [hw/rtcac_timebase.sv]
`timescale 1ns/1ps
module rtcac_timebase #(
  parameter int HALF_CYCLES = rtcac_pkg::HALF_SEC_CYCLES
) (
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // Events and time
  rtcac_core_if.timebase   tm
);
  localparam int CW = $clog2(HALF_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
    logic [3:0]    so;
    logic [2:0]    st;
    logic [3:0]    mo;
    logic [2:0]    mt;
    logic [3:0]    ho;
    logic [1:0]    ht;
    logic [2:0]    wd;
    logic [6:0]    ev;
  } rtcac_tb_st_t;

  rtcac_tb_st_t s_reg;
  rtcac_tb_st_t s_next;

  // Events carry over in a cascade so every boundary pulse is aligned
  always_comb begin
    s_next    = s_reg;
    s_next.ev = '0;
    if (s_reg.cnt == CW'(HALF_CYCLES - 1)) begin
      s_next.cnt   = '0;
      s_next.ev[0] = 1'b1;
      s_next.phase = ~s_reg.phase;
      if (s_reg.phase) begin
        s_next.ev[1] = 1'b1;
        if (s_reg.so == rtcac_pkg::BCD_MAX) begin
          s_next.so    = '0;
          s_next.ev[2] = 1'b1;
          if (s_reg.st == rtcac_pkg::TENS_MAX_MS) begin
            s_next.st    = '0;
            s_next.ev[3] = 1'b1;
            if (s_reg.mo == rtcac_pkg::BCD_MAX) begin
              s_next.mo    = '0;
              s_next.ev[4] = 1'b1;
              if (s_reg.mt == rtcac_pkg::TENS_MAX_MS) begin
                s_next.mt    = '0;
                s_next.ev[5] = 1'b1;
                if (s_reg.ht == rtcac_pkg::HR_TENS_LAST && s_reg.ho == rtcac_pkg::HR_ONES_LAST) begin
                  s_next.ht    = '0;
                  s_next.ho    = '0;
                  s_next.ev[6] = 1'b1;
                  s_next.wd    = (s_reg.wd == rtcac_pkg::WDAY_LAST) ? 3'h0 : s_reg.wd + 3'h1;
                end else if (s_reg.ho == rtcac_pkg::BCD_MAX) begin
                  s_next.ho = '0;
                  s_next.ht = s_reg.ht + 2'h1;
                end else begin
                  s_next.ho = s_reg.ho + 4'h1;
                end
              end else begin
                s_next.mt = s_reg.mt + 3'h1;
              end
            end else begin
              s_next.mo = s_reg.mo + 4'h1;
            end
          end else begin
            s_next.st = s_reg.st + 3'h1;
          end
        end else begin
          s_next.so = s_reg.so + 4'h1;
        end
      end
    end else begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tm.half    = s_reg.ev[0];
  assign tm.sec     = s_reg.ev[1];
  assign tm.ten_sec = s_reg.ev[2];
  assign tm.minute  = s_reg.ev[3];
  assign tm.ten_min = s_reg.ev[4];
  assign tm.hour    = s_reg.ev[5];
  assign tm.day     = s_reg.ev[6];
  assign tm.sec_bcd = {1'b0, s_reg.st, s_reg.so};
  assign tm.min_bcd = {1'b0, s_reg.mt, s_reg.mo};
  assign tm.hr_bcd  = {2'b00, s_reg.ht, s_reg.ho};
  assign tm.wday    = s_reg.wd;
endmodule

// [hw/rtcac_alarm_store.sv]
`timescale 1ns/1ps
module rtcac_alarm_store (
  // Clock and reset
  input wire logic     pclk,
  input wire logic     presetn,
  // Store port
  rtcac_core_if.store  st
);
  typedef struct packed {
    logic [3:0][15:0] words;
    logic [15:0]      rd;
  } rtcac_store_st_t;

  rtcac_store_st_t s_reg;
  rtcac_store_st_t s_next;

  // Read data trail the pointer by one cycle; bus reads sample it later
  always_comb begin
    s_next    = s_reg;
    s_next.rd = s_reg.words[st.idx];
    if (st.wr_en) begin
      s_next.words[st.idx] = st.wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign st.rd_data = s_reg.rd;
  assign st.words   = s_reg.words;
endmodule

// [hw/rtcac_top.sv]
// Functional notes
// - Mask 0010 fires every ten seconds, mask 0011 every minute.
// - Mask 0100 fires every ten minutes, mask 0101 every hour.
// - Window high byte: pointer picks month, weekday, minute or stamp alarm byte.
// - Window low byte: pointer picks second, hour, day or sample alarm byte.
// - Repeat count gives extra alarms; all ones 255 more, zero just one; with chime set, zero reloads all ones and alarms go on.
// - Year tens BCD digit in bits 7-4, values 0 to 9.
// - Year ones BCD digit in bits 3-0, values 0 to 9.
// - Year bits 15-8 always read zero.
// - Year and month/day accept writes only while calendar write enable is 1.
// - Month tens bit 12, month ones bits 11-8; bits 15-13 read zero.
// - Day tens bits 5-4 up to 3, day ones bits 3-0; bits 7-6 zero.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module rtcac_top #(
  parameter int HALF_SEC_CYCLES = rtcac_pkg::HALF_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Alarm and interrupt
  output logic             alarm_event,
  output logic             irq
);
  typedef struct packed {
    logic        wren;
    logic        alen;
    logic        chime;
    logic [3:0]  mask;
    logic [1:0]  ptr;
    logic [7:0]  rpt;
    logic [7:0]  year;
    logic [15:0] calendar_month_day_value;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        alarm;
  } rtcac_top_st_t;

  localparam rtcac_top_st_t TOP_RST = '{
    year:    rtcac_pkg::YEAR_RST,
    calendar_month_day_value:   rtcac_pkg::CALENDAR_MONTH_DAY_VALUE_RST,
    default: '0
  };

  rtcac_top_st_t s_reg;
  rtcac_top_st_t s_next;

  rtcac_core_if cif();

  rtcac_timebase #(
    .HALF_CYCLES (HALF_SEC_CYCLES)
  ) u_timebase (
    .pclk    (pclk),
    .presetn (presetn),
    .tm      (cif.timebase)
  );

  rtcac_alarm_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .st      (cif.store)
  );

  logic       acc;
  logic       done;
  logic       wr;
  logic       cal_wr;
  logic       year_ok;
  logic       calendar_month_day_value_ok;
  logic       mapped;
  logic       hms_eq;
  logic       wday_eq;
  logic       day_eq;
  logic       mth_eq;
  logic       hit;
  logic       fire;
  logic       blk;
  logic [1:0] clr;

  // First access cycle raises pready; the write lands on the completing edge
  assign acc    = psel & penable & ~s_reg.pready;
  assign done   = psel & penable & s_reg.pready;
  assign wr     = done & pwrite;
  assign cal_wr = wr & ((paddr == rtcac_pkg::OFF_YEAR) | (paddr == rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE));

  assign year_ok  = (pwdata[7:4] <= rtcac_pkg::BCD_MAX) && (pwdata[3:0] <= rtcac_pkg::BCD_MAX);
  assign calendar_month_day_value_ok = (pwdata[11:8] <= rtcac_pkg::BCD_MAX) && (pwdata[3:0] <= rtcac_pkg::BCD_MAX);

  assign mapped = (paddr == rtcac_pkg::OFF_ALCFG)   || (paddr == rtcac_pkg::OFF_ALVAL)   ||
                  (paddr == rtcac_pkg::OFF_YEAR)    || (paddr == rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE)   ||
                  (paddr == rtcac_pkg::OFF_CTRL)    || (paddr == rtcac_pkg::OFF_IRQ_STS) ||
                  (paddr == rtcac_pkg::OFF_IRQ_MSK) || (paddr == rtcac_pkg::OFF_TIME);

  // Window accesses go to the word that the pointer selects
  assign cif.wr_en   = wr & (paddr == rtcac_pkg::OFF_ALVAL);
  assign cif.idx     = s_reg.ptr;
  assign cif.wr_data = pwdata[15:0];

  // Calendar compares; day and month come from the software calendar registers
  assign hms_eq  = (cif.sec_bcd == cif.words[rtcac_pkg::PTR_MTH_SEC][7:0]) &&
                   (cif.min_bcd == cif.words[rtcac_pkg::PTR_MIN_DAY][15:8]) &&
                   (cif.hr_bcd == cif.words[rtcac_pkg::PTR_WDY_HR][7:0]);
  assign wday_eq = {5'h00, cif.wday} == cif.words[rtcac_pkg::PTR_WDY_HR][15:8];
  assign day_eq  = {2'b00, s_reg.calendar_month_day_value[5:0]} == cif.words[rtcac_pkg::PTR_MIN_DAY][7:0];
  assign mth_eq  = {3'b000, s_reg.calendar_month_day_value[12:8]} == cif.words[rtcac_pkg::PTR_MTH_SEC][15:8];

  always_comb begin
    case (s_reg.mask)
      rtcac_pkg::MASK_HALF_SEC: hit = cif.half;
      rtcac_pkg::MASK_SEC:      hit = cif.sec;
      rtcac_pkg::MASK_TEN_SEC:  hit = cif.ten_sec;
      rtcac_pkg::MASK_MIN:      hit = cif.minute;
      rtcac_pkg::MASK_TEN_MIN:  hit = cif.ten_min;
      rtcac_pkg::MASK_HOUR:     hit = cif.hour;
      rtcac_pkg::MASK_DAY:      hit = cif.sec & hms_eq;
      rtcac_pkg::MASK_WEEK:     hit = cif.sec & hms_eq & wday_eq;
      rtcac_pkg::MASK_MONTH:    hit = cif.sec & hms_eq & day_eq;
      rtcac_pkg::MASK_YEAR:     hit = cif.sec & hms_eq & day_eq & mth_eq;
      // Reserved codes stay silent rather than guess an interval
      default:                  hit = 1'b0;
    endcase
  end

  assign fire = s_reg.alen & hit;
  assign blk  = cal_wr & ~(s_reg.wren & ((paddr == rtcac_pkg::OFF_YEAR) ? year_ok : calendar_month_day_value_ok));

  always_comb begin
    s_next       = s_reg;
    clr          = 2'b00;
    s_next.alarm = fire;
    if (fire) begin
      if (s_reg.rpt != 8'h00) begin
        s_next.rpt = s_reg.rpt - 8'h01;
      end else if (s_reg.chime) begin
        s_next.rpt = 8'hff;
      end else begin
        s_next.alen = 1'b0;
      end
    end
    // A bus write in the same cycle overrides the hardware update
    if (wr) begin
      case (paddr)
        rtcac_pkg::OFF_ALCFG: begin
          s_next.mask = pwdata[rtcac_pkg::MASK_LSB +: 4];
          s_next.ptr  = pwdata[rtcac_pkg::PTR_LSB +: 2];
          s_next.rpt  = pwdata[7:0];
        end
        rtcac_pkg::OFF_YEAR: begin
          if (s_reg.wren && year_ok) begin
            s_next.year = pwdata[7:0];
          end
        end
        rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE: begin
          if (s_reg.wren && calendar_month_day_value_ok) begin
            s_next.calendar_month_day_value = pwdata[15:0] & rtcac_pkg::CALENDAR_MONTH_DAY_VALUE_MASK;
          end
        end
        rtcac_pkg::OFF_CTRL: begin
          s_next.wren  = pwdata[rtcac_pkg::CTRL_WREN_BIT];
          s_next.alen  = pwdata[rtcac_pkg::CTRL_ALEN_BIT];
          s_next.chime = pwdata[rtcac_pkg::CTRL_CHIME_BIT];
        end
        rtcac_pkg::OFF_IRQ_STS: begin
          clr = pwdata[1:0];
        end
        rtcac_pkg::OFF_IRQ_MSK: begin
          s_next.msk = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // Set beats clear so an event in the clearing cycle survives
    s_next.sts[rtcac_pkg::IRQ_ALARM_BIT] = (s_reg.sts[rtcac_pkg::IRQ_ALARM_BIT] &
                                            ~clr[rtcac_pkg::IRQ_ALARM_BIT]) | fire;
    s_next.sts[rtcac_pkg::IRQ_WBLK_BIT]  = (s_reg.sts[rtcac_pkg::IRQ_WBLK_BIT] &
                                            ~clr[rtcac_pkg::IRQ_WBLK_BIT]) | blk;
    s_next.irq     = |(s_next.sts & s_next.msk);
    s_next.pready  = acc;
    s_next.pslverr = acc & ~mapped;
    s_next.prdata  = 32'h0000_0000;
    if (acc && !pwrite) begin
      case (paddr)
        rtcac_pkg::OFF_ALCFG: begin
          s_next.prdata = {18'h00000, s_reg.mask, s_reg.ptr, s_reg.rpt};
        end
        rtcac_pkg::OFF_ALVAL: begin
          s_next.prdata = {16'h0000, cif.rd_data};
        end
        rtcac_pkg::OFF_YEAR: begin
          s_next.prdata = {24'h000000, s_reg.year};
        end
        rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE: begin
          s_next.prdata = {16'h0000, s_reg.calendar_month_day_value};
        end
        rtcac_pkg::OFF_CTRL: begin
          s_next.prdata = {29'h00000000, s_reg.chime, s_reg.alen, s_reg.wren};
        end
        rtcac_pkg::OFF_IRQ_STS: begin
          s_next.prdata = {30'h00000000, s_reg.sts};
        end
        rtcac_pkg::OFF_IRQ_MSK: begin
          s_next.prdata = {30'h00000000, s_reg.msk};
        end
        rtcac_pkg::OFF_TIME: begin
          s_next.prdata = {5'h00, cif.wday, cif.hr_bcd, cif.min_bcd, cif.sec_bcd};
        end
        default: begin
          s_next.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= TOP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata      = s_reg.prdata;
  assign pready      = s_reg.pready;
  assign pslverr     = s_reg.pslverr;
  assign alarm_event = s_reg.alarm;
  assign irq         = s_reg.irq;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_win;
  logic rd_year;
  assign rd_win  = acc & ~pwrite & (paddr == rtcac_pkg::OFF_ALVAL);
  assign rd_year = acc & ~pwrite & (paddr == rtcac_pkg::OFF_YEAR);

  chk_ten_sec_rate: assert property (
    (s_reg.alen && s_reg.mask == rtcac_pkg::MASK_TEN_SEC) |=> (alarm_event == $past(cif.ten_sec)))
    else $error("ten second alarm mismatch");
  chk_minute_rate: assert property (
    (s_reg.alen && s_reg.mask == rtcac_pkg::MASK_MIN) |=> (alarm_event == $past(cif.minute)))
    else $error("minute alarm mismatch");
  chk_ten_min_rate: assert property (
    (s_reg.alen && s_reg.mask == rtcac_pkg::MASK_TEN_MIN) |=> (alarm_event == $past(cif.ten_min)))
    else $error("ten minute alarm mismatch");
  chk_hour_rate: assert property (
    (s_reg.alen && s_reg.mask == rtcac_pkg::MASK_HOUR) |=> (alarm_event == $past(cif.hour)))
    else $error("hour alarm mismatch");
  chk_window_high: assert property (
    rd_win |=> (prdata[15:8] == $past(cif.words[s_reg.ptr][15:8], 2)) && pready)
    else $error("window high byte wrong");
  chk_window_low: assert property (
    rd_win |=> (prdata[7:0] == $past(cif.words[s_reg.ptr][7:0], 2)))
    else $error("window low byte wrong");
  chk_repeat_dec: assert property (
    (fire && s_reg.rpt != 8'h00 && !(wr && paddr == rtcac_pkg::OFF_ALCFG))
      |=> (s_reg.rpt == $past(s_reg.rpt) - 8'h01) && alarm_event)
    else $error("repeat count did not step down");
  chk_last_alarm: assert property (
    (fire && s_reg.rpt == 8'h00 && !s_reg.chime && !(wr && paddr == rtcac_pkg::OFF_CTRL))
      |=> !s_reg.alen ##1 !alarm_event)
    else $error("alarm kept running after last repeat");
  chk_year_digits: assert property (
    (s_reg.year[7:4] <= rtcac_pkg::BCD_MAX) && (s_reg.year[3:0] <= rtcac_pkg::BCD_MAX))
    else $error("year digit out of range");
  chk_year_upper: assert property (
    rd_year |=> (prdata[31:8] == 24'h000000))
    else $error("year upper bits not zero");
  chk_cal_guard: assert property (
    (cal_wr && !s_reg.wren) |=> $stable(s_reg.year) && $stable(s_reg.calendar_month_day_value) &&
      s_reg.sts[rtcac_pkg::IRQ_WBLK_BIT])
    else $error("calendar changed without write enable");
  chk_month_fields: assert property (
    (s_reg.calendar_month_day_value[15:13] == 3'h0) && (s_reg.calendar_month_day_value[11:8] <= rtcac_pkg::BCD_MAX))
    else $error("month field out of range");
  chk_day_fields: assert property (
    (s_reg.calendar_month_day_value[7:6] == 2'h0) && (s_reg.calendar_month_day_value[3:0] <= rtcac_pkg::BCD_MAX))
    else $error("day field out of range");

  cov_ten_sec_alarm: cover property (
    s_reg.mask == rtcac_pkg::MASK_TEN_SEC && fire);
  cov_repeat_run_out: cover property (
    fire && s_reg.rpt == 8'h01 ##[1:1000] fire && s_reg.rpt == 8'h00);
  cov_blocked_write: cover property (blk);
  cov_window_read: cover property (rd_win ##1 pready);
endmodule

// [tb/rtcac_top_tb.sv]
`timescale 1ns/1ps
module rtcac_top_tb;
  // Short timebase: half second = 4 cycles
  localparam int H = 4;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        alarm_event;
  logic        irq;
  int          error_cnt;
  int          tests_run;

  rtcac_top #(.HALF_SEC_CYCLES(H)) i_rtcac_top (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .alarm_event (alarm_event),
    .irq         (irq)
  );

  always #5 pclk = ~pclk;

  task automatic finish_test();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        error_cnt++;
        finish_test();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_reset_map();
    logic [31:0] r;
    logic        e;
    rd_chk(rtcac_pkg::OFF_YEAR, {24'h0, rtcac_pkg::YEAR_RST});
    rd_chk(rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE, {16'h0, rtcac_pkg::CALENDAR_MONTH_DAY_VALUE_RST});
    rd_chk(rtcac_pkg::OFF_ALCFG, 32'h0);
    apb(1'b1, 8'h20, 32'hffff_ffff, r, e);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
  endtask

  task automatic t_calendar();
    wr(rtcac_pkg::OFF_CTRL, 32'h0);
    wr(rtcac_pkg::OFF_YEAR, 32'h0000_0042);
    rd_chk(rtcac_pkg::OFF_YEAR, 32'h0);
    rd_chk(rtcac_pkg::OFF_IRQ_STS, 32'h2);
    wr(rtcac_pkg::OFF_IRQ_MSK, 32'h2);
    idle(2);
    check({31'h0, irq}, 32'h1);
    wr(rtcac_pkg::OFF_IRQ_MSK, 32'h0);
    idle(2);
    check({31'h0, irq}, 32'h0);
    wr(rtcac_pkg::OFF_IRQ_MSK, 32'h2);
    wr(rtcac_pkg::OFF_IRQ_STS, 32'h2);
    idle(2);
    check({31'h0, irq}, 32'h0);
    rd_chk(rtcac_pkg::OFF_IRQ_STS, 32'h0);
    wr(rtcac_pkg::OFF_CTRL, 32'h1);
    wr(rtcac_pkg::OFF_YEAR, 32'hffff_ff97);
    rd_chk(rtcac_pkg::OFF_YEAR, 32'h97);
    wr(rtcac_pkg::OFF_YEAR, 32'h0000_009a);
    rd_chk(rtcac_pkg::OFF_YEAR, 32'h97);
    wr(rtcac_pkg::OFF_YEAR, 32'h0000_00a0);
    rd_chk(rtcac_pkg::OFF_YEAR, 32'h97);
    // Unimplemented bits all set to prove they are dropped
    wr(rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE, 32'hffff_f2f9);
    rd_chk(rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE, 32'h1239);
    wr(rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE, 32'h0000_0a01);
    rd_chk(rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE, 32'h1239);
    wr(rtcac_pkg::OFF_CTRL, 32'h0);
    wr(rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE, 32'h0000_0101);
    rd_chk(rtcac_pkg::OFF_CALENDAR_MONTH_DAY_VALUE, 32'h1239);
    wr(rtcac_pkg::OFF_IRQ_STS, 32'h3);
    wr(rtcac_pkg::OFF_IRQ_MSK, 32'h0);
  endtask

  task automatic t_window();
    logic [15:0] v [4];
    v = '{16'h1259, 16'h0623, 16'h4531, 16'h3c7e};
    for (int p = 0; p < 4; p++) begin
      wr(rtcac_pkg::OFF_ALCFG, {22'h0, 2'(p), 8'h0});
      wr(rtcac_pkg::OFF_ALVAL, {16'h0, v[p]});
    end
    for (int p = 3; p >= 0; p--) begin
      wr(rtcac_pkg::OFF_ALCFG, {22'h0, 2'(p), 8'h0});
      rd_chk(rtcac_pkg::OFF_ALCFG, {22'h0, 2'(p), 8'h0});
      rd_chk(rtcac_pkg::OFF_ALVAL, {16'h0, v[p]});
    end
  endtask

  // Stops early once nexp alarms are seen unless full, which also proves no extra
  task automatic t_alarm(input logic [3:0] m, input logic [7:0] rpt, input int per,
                         input int nexp, input bit full);
    int cnt;
    int last;
    int gap;
    int lim;
    lim = (nexp + 1) * per + 40;
    cnt = 0;
    last = 0;
    gap = 0;
    wr(rtcac_pkg::OFF_IRQ_STS, 32'h3);
    wr(rtcac_pkg::OFF_IRQ_MSK, 32'h1);
    wr(rtcac_pkg::OFF_ALCFG, {18'h0, m, 2'h0, rpt});
    wr(rtcac_pkg::OFF_CTRL, 32'h2);
    for (int cyc = 0; cyc < lim; cyc++) begin
      @(posedge pclk);
      if (alarm_event === 1'b1) begin
        if (cnt > 0) begin
          gap = cyc - last;
        end
        last = cyc;
        cnt++;
        if (cnt == nexp && !full) begin
          break;
        end
      end
    end
    check(32'(gap), 32'(per));
    check(32'(cnt), 32'(nexp));
    check({31'h0, irq}, 32'h1);
    if (full) begin
      rd_chk(rtcac_pkg::OFF_CTRL, 32'h0);
      rd_chk(rtcac_pkg::OFF_ALCFG, {18'h0, m, 2'h0, 8'h0});
    end
    wr(rtcac_pkg::OFF_CTRL, 32'h0);
    wr(rtcac_pkg::OFF_IRQ_STS, 32'h1);
    idle(2);
    check({31'h0, irq}, 32'h0);
  endtask

  // Runs straight after the hourly test, so the clock stands a few seconds past 02:00:00
  // Mask codes are kept at or below the yearly setting
  task automatic t_daily();
    int          cnt;
    logic [15:0] w [3];
    w = '{16'h0020, 16'h0002, 16'h0000};
    cnt = 0;
    for (int p = 0; p < 3; p++) begin
      wr(rtcac_pkg::OFF_ALCFG, {22'h0, 2'(p), 8'h0});
      wr(rtcac_pkg::OFF_ALVAL, {16'h0, w[p]});
    end
    wr(rtcac_pkg::OFF_ALCFG, {18'h0, 4'h6, 2'h0, 8'h0});
    wr(rtcac_pkg::OFF_CTRL, 32'h2);
    for (int cyc = 0; cyc < 400; cyc++) begin
      @(posedge pclk);
      if (alarm_event === 1'b1) begin
        cnt++;
      end
    end
    check(32'(cnt), 32'h1);
    rd_chk(rtcac_pkg::OFF_CTRL, 32'h0);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_calendar();
    t_window();
    t_alarm(4'h0, 8'hff, H, 256, 1'b1);
    t_alarm(4'h2, 8'h02, 20 * H, 3, 1'b1);
    t_alarm(4'h3, 8'h01, 120 * H, 2, 1'b0);
    t_alarm(4'h4, 8'h01, 1200 * H, 2, 1'b0);
    t_alarm(4'h5, 8'h01, 7200 * H, 2, 1'b0);
    t_daily();
    finish_test();
  end
endmodule
